//--- rtl/vri_regs.v
// vme register access window, csr window translation and posted-write bus error log
// assumes vme cycle fields and error events arrive already synchronous to clk_sys;
// power-up option straps pass two flops and load while rst is high, so rst spans three edges
// or more; register port is 32-bit, word aligned
//
// Summary of operation
// - window accepts only single-cycle and lock am codes
// - rmw access locks registers until one cycle past the cycle end
// - window decodes only while enable bit set
// - program/data qualifier limits am codes, resets 11
// - privilege qualifier limits am codes, resets 11
// - space select: 00 a16, 01 a24, 10 a32
// - 4 kbyte window, base in bits 31:12
// - base resets from power-up address bits per space
// - csr enable set on level 2 auto-id
// - csr pci space select, memory or i/o
// - add offset to 24-bit address for pci
// - bus error captures am code and iack
// - valid flag freezes logs, write one clears
// - multiple-error flag set on error while frozen
// - failing address captured in address log
`include "vri_defs.vh"
module vri_regs (
  input  wire        clk_sys,
  input  wire        rst,
  // power-up option straps
  input  wire        pu_win_en,
  input  wire [1:0]  pu_space,
  input  wire [7:0]  powerup_address_bits,
  input  wire [4:0]  pu_ofs_mid,
  // local register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata_ff,
  output reg         reg_busy_ff,
  // incoming vme slave cycle
  input  wire        vme_cyc,
  input  wire [31:0] vme_addr,
  input  wire [5:0]  vme_am,
  input  wire        vme_rmw,
  input  wire        vme_wr,
  input  wire [31:0] vme_wdata,
  output reg         win_hit_ff,
  output reg  [31:0] vme_rdata_ff,
  // csr space translation
  input  wire        csr_cyc,
  input  wire [23:0] csr_addr,
  output reg  [31:0] csr_pci_addr_ff,
  output reg  [1:0]  csr_pci_space_ff,
  output reg         csr_en_ff,
  input  wire        autoid_l2_ack,
  // posted write bus error event
  input  wire        berr_evt,
  input  wire [5:0]  berr_am,
  input  wire        berr_iack,
  input  wire [31:0] berr_addr
);
  // strap synchroniser stages
  reg        pu_win_en_s1_ff;
  reg        pu_win_en_s2_ff;
  reg [1:0]  pu_space_s1_ff;
  reg [1:0]  pu_space_s2_ff;
  reg [7:0]  pu_addr_s1_ff;
  reg [7:0]  pu_addr_s2_ff;
  reg [4:0]  pu_ofs_s1_ff;
  reg [4:0]  pu_ofs_s2_ff;
  // register window control state
  reg        win_en_ff;
  reg [1:0]  program_data_qualifier_ff;
  reg [1:0]  priv_qual_ff;
  reg [1:0]  vme_space_select_ff;
  reg [19:0] window_base_field_ff;
  // csr window control state
  reg [1:0]  pci_space_select_ff;
  reg [12:0] translation_offset_field_ff;
  // bus error logs
  reg [5:0]  am_code_log_ff;
  reg        iack_log_ff;
  reg        multi_err_ff;
  reg        log_valid_ff;
  reg [31:0] bus_error_address_log_ff;
  // rmw lock and decode helpers
  reg        lock_ff;
  reg [19:0] rst_base;
  reg        am_ok;
  reg        range_ok;
  reg        hit;
  reg [31:0] rd_mux;
  reg [31:0] win_rd;
  // shared write path
  wire [11:0] win_off;
  wire        loc_wr;
  wire        vme_wr_hit;
  wire [11:0] wr_off;
  wire [31:0] wr_data;
  wire        any_wr;

  // two-flop strap synchroniser; the pins are static, so no reset term
  always @(posedge clk_sys) begin
    pu_win_en_s1_ff <= pu_win_en;
    pu_win_en_s2_ff <= pu_win_en_s1_ff;
    pu_space_s1_ff  <= pu_space;
    pu_space_s2_ff  <= pu_space_s1_ff;
    pu_addr_s1_ff   <= powerup_address_bits;
    pu_addr_s2_ff   <= pu_addr_s1_ff;
    pu_ofs_s1_ff    <= pu_ofs_mid;
    pu_ofs_s2_ff    <= pu_ofs_s1_ff;
  end

  // base reset value follows the strapped space
  always @* begin
    // base bits outside the strapped byte stay zero
    rst_base = 20'h00000;
    case (pu_space_s2_ff)
      `VRI_SPC_A16: rst_base[3:0]   = pu_addr_s2_ff[7:4];
      `VRI_SPC_A24: rst_base[11:4]  = pu_addr_s2_ff;
      `VRI_SPC_A32: rst_base[19:12] = pu_addr_s2_ff;
      default:      rst_base = 20'h00000;
    endcase
  end

  // am code qualification: single-cycle and lock codes only, no block transfers
  always @* begin
    am_ok = 1'b0;
    case (vme_am)
      // a16 supervisor and user
      6'h2d: am_ok = (vme_space_select_ff == `VRI_SPC_A16) && priv_qual_ff[1]
                     && program_data_qualifier_ff[0];
      6'h29: am_ok = (vme_space_select_ff == `VRI_SPC_A16) && priv_qual_ff[0]
                     && program_data_qualifier_ff[0];
      // a24 supervisor data and program
      6'h3d, 6'h3e: am_ok = (vme_space_select_ff == `VRI_SPC_A24) && priv_qual_ff[1]
                     && program_data_qualifier_ff[vme_am[1]];
      // a24 user data and program
      6'h39, 6'h3a: am_ok = (vme_space_select_ff == `VRI_SPC_A24) && priv_qual_ff[0]
                     && program_data_qualifier_ff[vme_am[1]];
      // a32 supervisor data and program
      6'h0d, 6'h0e: am_ok = (vme_space_select_ff == `VRI_SPC_A32) && priv_qual_ff[1]
                     && program_data_qualifier_ff[vme_am[1]];
      // a32 user data and program
      6'h09, 6'h0a: am_ok = (vme_space_select_ff == `VRI_SPC_A32) && priv_qual_ff[0]
                     && program_data_qualifier_ff[vme_am[1]];
      // lock codes ignore the program and privilege qualifiers
      6'h32: am_ok = (vme_space_select_ff == `VRI_SPC_A24);
      6'h05: am_ok = (vme_space_select_ff == `VRI_SPC_A32);
      6'h2c: am_ok = (vme_space_select_ff == `VRI_SPC_A16);
      default: am_ok = 1'b0;
    endcase
  end

  // address range check against the base within the selected space width
  always @* begin
    case (vme_space_select_ff)
      `VRI_SPC_A16: range_ok = (vme_addr[15:12] == window_base_field_ff[3:0]);
      `VRI_SPC_A24: range_ok = (vme_addr[23:12] == window_base_field_ff[11:0]);
      `VRI_SPC_A32: range_ok = (vme_addr[31:12] == window_base_field_ff);
      // reserved space codes never hit
      default:      range_ok = 1'b0;
    endcase
    hit = vme_cyc && win_en_ff && range_ok && am_ok;
  end

  assign win_off    = vme_addr[11:0];
  // local writes are dropped while a vme hit or the rmw lock holds the registers
  assign loc_wr     = reg_wr && !lock_ff && !hit;
  // a vme write hit takes the shared write path ahead of the local port
  assign vme_wr_hit = hit && vme_wr;
  assign wr_off     = vme_wr_hit ? {win_off[11:2], 2'b00} : {reg_addr[11:2], 2'b00};
  assign wr_data    = vme_wr_hit ? vme_wdata : reg_wdata;
  assign any_wr     = vme_wr_hit || loc_wr;

  // shared read decode
  function [31:0] rd_sel;
    input [11:0] off;
    begin
      // reserved bits read as zero
      rd_sel = 32'h00000000;
      case ({off[11:2], 2'b00})
        `VRI_OFF_RW_CTL: begin
          rd_sel[`VRI_EN_BIT] = win_en_ff;
          rd_sel[`VRI_PGM_HI:`VRI_PGM_LO] = program_data_qualifier_ff;
          rd_sel[`VRI_SUP_HI:`VRI_SUP_LO] = priv_qual_ff;
          rd_sel[`VRI_VAS_HI:`VRI_VAS_LO] = vme_space_select_ff;
        end
        `VRI_OFF_RW_BASE: rd_sel[`VRI_BS_HI:`VRI_BS_LO] = window_base_field_ff;
        `VRI_OFF_CSR_CTL: begin
          rd_sel[`VRI_EN_BIT] = csr_en_ff;
          rd_sel[`VRI_LAS_HI:`VRI_LAS_LO] = pci_space_select_ff;
        end
        `VRI_OFF_CSR_OFS: rd_sel[`VRI_TO_HI:`VRI_TO_LO] = translation_offset_field_ff;
        `VRI_OFF_AM_LOG: begin
          rd_sel[`VRI_AML_HI:`VRI_AML_LO] = am_code_log_ff;
          rd_sel[`VRI_IACK_BIT]  = iack_log_ff;
          rd_sel[`VRI_MERR_BIT]  = multi_err_ff;
          rd_sel[`VRI_VSTAT_BIT] = log_valid_ff;
        end
        `VRI_OFF_ADR_LOG: rd_sel = bus_error_address_log_ff;
        default: rd_sel = 32'h00000000;
      endcase
    end
  endfunction

  // one decode serves the local port and the window
  always @* begin
    rd_mux = rd_sel(reg_addr);
    win_rd = rd_sel(win_off);
  end

  // register writes, lock tracking and read return
  always @(posedge clk_sys) begin
    if (rst) begin
      // straps load from the synchroniser while rst is high
      win_en_ff                   <= pu_win_en_s2_ff;
      program_data_qualifier_ff   <= `VRI_RST_QUAL;
      priv_qual_ff                <= `VRI_RST_QUAL;
      vme_space_select_ff         <= pu_space_s2_ff;
      window_base_field_ff        <= rst_base;
      csr_en_ff                   <= `VRI_RST_CSR_EN;
      pci_space_select_ff         <= `VRI_RST_LAS;
      translation_offset_field_ff <= {`VRI_RST_HI_OFS, pu_ofs_s2_ff};
      lock_ff                     <= 1'b0;
      reg_busy_ff                 <= 1'b0;
      reg_rdata_ff                <= 32'h00000000;
      vme_rdata_ff                <= 32'h00000000;
      win_hit_ff                  <= 1'b0;
    end else begin
      // lock stands one cycle past each rmw hit cycle
      lock_ff     <= hit && vme_rmw;
      reg_busy_ff <= (reg_wr || reg_rd) && (lock_ff || hit);
      win_hit_ff  <= hit;
      // window read data stands only for a hit
      vme_rdata_ff <= hit ? win_rd : 32'h00000000;
      // a refused read leaves the last data standing
      if (reg_rd && !lock_ff && !hit)
        reg_rdata_ff <= rd_mux;
      if (any_wr) begin
        case (wr_off)
          `VRI_OFF_RW_CTL: begin
            win_en_ff                 <= wr_data[`VRI_EN_BIT];
            program_data_qualifier_ff <= wr_data[`VRI_PGM_HI:`VRI_PGM_LO];
            priv_qual_ff              <= wr_data[`VRI_SUP_HI:`VRI_SUP_LO];
            vme_space_select_ff       <= wr_data[`VRI_VAS_HI:`VRI_VAS_LO];
          end
          `VRI_OFF_RW_BASE: window_base_field_ff <= wr_data[`VRI_BS_HI:`VRI_BS_LO];
          `VRI_OFF_CSR_CTL: begin
            csr_en_ff           <= wr_data[`VRI_EN_BIT] || autoid_l2_ack;
            pci_space_select_ff <= wr_data[`VRI_LAS_HI:`VRI_LAS_LO];
          end
          `VRI_OFF_CSR_OFS: translation_offset_field_ff <= wr_data[`VRI_TO_HI:`VRI_TO_LO];
          default: ;
        endcase
      end
      // auto-id set wins over a write of zero
      if (autoid_l2_ack)
        csr_en_ff <= 1'b1;
    end
  end

  // csr window address translation
  always @(posedge clk_sys) begin
    if (rst) begin
      csr_pci_addr_ff  <= 32'h00000000;
      csr_pci_space_ff <= 2'h0;
    end else if (csr_cyc && csr_en_ff) begin
      // the carry out of bit 31 drops, so the sum wraps
      csr_pci_addr_ff  <= {8'h00, csr_addr} + {translation_offset_field_ff, 19'h00000};
      csr_pci_space_ff <= pci_space_select_ff;
    end
  end

  // bus error log, frozen while valid; a new error beats the clear
  always @(posedge clk_sys) begin
    if (rst) begin
      am_code_log_ff           <= 6'h00;
      iack_log_ff              <= 1'b0;
      multi_err_ff             <= 1'b0;
      log_valid_ff             <= 1'b0;
      bus_error_address_log_ff <= 32'h00000000;
    end else begin
      // software clear: a one written to the valid flag
      if (any_wr && wr_off == `VRI_OFF_AM_LOG && wr_data[`VRI_VSTAT_BIT]) begin
        log_valid_ff <= 1'b0;
        multi_err_ff <= 1'b0;
      end
      // the first error fills the logs, later ones only flag
      if (berr_evt) begin
        if (!log_valid_ff) begin
          am_code_log_ff           <= berr_am;
          iack_log_ff              <= berr_iack;
          bus_error_address_log_ff <= berr_addr;
          log_valid_ff             <= 1'b1;
          multi_err_ff             <= 1'b0;
        end else begin
          multi_err_ff <= 1'b1;
          log_valid_ff <= 1'b1;
        end
      end
    end
  end
endmodule // vri_regs

//--- inc/vri_defs.vh
// offsets, field positions, reset values and space codes for the vme register image block
// assumes a 32-bit register port with 12-bit byte offsets, word aligned
`ifndef VRI_DEFS_VH
`define VRI_DEFS_VH
// register offsets
`define VRI_OFF_RW_CTL   12'hf70
`define VRI_OFF_RW_BASE  12'hf74
`define VRI_OFF_CSR_CTL  12'hf80
`define VRI_OFF_CSR_OFS  12'hf84
`define VRI_OFF_AM_LOG   12'hf88
`define VRI_OFF_ADR_LOG  12'hf8c
// control field positions
`define VRI_EN_BIT       31
`define VRI_PGM_HI       23
`define VRI_PGM_LO       22
`define VRI_SUP_HI       21
`define VRI_SUP_LO       20
`define VRI_VAS_HI       17
`define VRI_VAS_LO       16
`define VRI_LAS_HI       1
`define VRI_LAS_LO       0
// base and offset field positions
`define VRI_BS_HI        31
`define VRI_BS_LO        12
`define VRI_TO_HI        31
`define VRI_TO_LO        19
// error log field positions
`define VRI_AML_HI       31
`define VRI_AML_LO       26
`define VRI_IACK_BIT     25
`define VRI_MERR_BIT     24
`define VRI_VSTAT_BIT    23
// reset values
`define VRI_RST_QUAL     2'h3
`define VRI_RST_LAS      2'h0
`define VRI_RST_HI_OFS   8'h00
`define VRI_RST_CSR_EN   1'b0
// space codes
`define VRI_SPC_A16      2'h0
`define VRI_SPC_A24      2'h1
`define VRI_SPC_A32      2'h2
// window size, 4 kbyte, in bits of address below the base field
`define VRI_WIN_BITS     12
`endif

//--- testbench/vri_regs_sva.sv
// concurrent checks on the vme register image ports
// assumes one clock clk_sys and a synchronous active-high rst
module vri_regs_chk (
  input logic        clk_sys,
  input logic        rst,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic        reg_busy_ff,
  input logic [31:0] reg_rdata_ff,
  input logic        vme_cyc,
  input logic [5:0]  vme_am,
  input logic        vme_rmw,
  input logic        win_hit_ff,
  input logic        csr_cyc,
  input logic [23:0] csr_addr,
  input logic [31:0] csr_pci_addr_ff,
  input logic        csr_en_ff,
  input logic        autoid_l2_ack
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // decode, lock, translation and enable relations
  a_hit_cause: assert property (win_hit_ff |-> $past(vme_cyc)) else $error("stray hit");
  a_block_am: assert property (vme_cyc && vme_am inside {6'h0b, 6'h0f, 6'h3b, 6'h3f}
    |=> !win_hit_ff) else $error("block am decoded");
  a_lock_refuse: assert property (win_hit_ff && $past(vme_rmw) && (reg_rd || reg_wr)
    |=> reg_busy_ff) else $error("access taken in lock");
  a_busy_cause: assert property (reg_busy_ff |-> $past(reg_rd || reg_wr)
    && ($past(vme_cyc) || $past(vme_cyc, 2))) else $error("busy without cause");
  a_xlate_low: assert property (csr_cyc && csr_en_ff
    |=> csr_pci_addr_ff[18:0] == $past(csr_addr[18:0])) else $error("low bits altered");
  a_autoid_en: assert property (autoid_l2_ack |=> csr_en_ff) else $error("no auto enable");
  a_en_hold: assert property (csr_en_ff && !reg_wr && !vme_cyc |=> csr_en_ff)
    else $error("enable lost");
  a_rdata_hold: assert property (!rst && !reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data moved");
endmodule // vri_regs_chk
bind vri_regs vri_regs_chk u_chk (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_busy_ff, .reg_rdata_ff,
  .vme_cyc, .vme_am, .vme_rmw, .win_hit_ff, .csr_cyc, .csr_addr, .csr_pci_addr_ff, .csr_en_ff,
  .autoid_l2_ack);

//--- testbench/vri_vme_master.sv
// vme master model issuing cycles into the register window
// assumes the block samples its vme inputs on rising clk_sys edges
module vri_vme_master (
  input  logic        clk_sys,
  input  logic        win_hit_ff,
  input  logic [31:0] vme_rdata_ff,
  output logic        vme_cyc,
  output logic        vme_rmw,
  output logic        vme_wr,
  output logic [31:0] vme_addr,
  output logic [5:0]  vme_am,
  output logic [31:0] vme_wdata
);
  // idle bus at time zero
  initial {vme_cyc, vme_rmw, vme_wr, vme_addr, vme_am, vme_wdata} = '0;
  // cycle held n edges; on release control lines drop, am holds, address and data show the inverse of their last value
  task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic w,
                     input logic [31:0] d, input logic lk, input int n,
                     output logic hit, output logic [31:0] rd);
    @(posedge clk_sys);
    #1;
    {vme_cyc, vme_rmw, vme_wr, vme_addr, vme_am, vme_wdata} = {1'b1, lk, w, a, m, d};
    repeat (n) @(posedge clk_sys);
    #1;
    hit = win_hit_ff;
    rd = vme_rdata_ff;
    {vme_cyc, vme_rmw, vme_wr} = 3'h0;
    vme_addr = ~a;
    vme_wdata = ~d;
  endtask
endmodule // vri_vme_master

//--- testbench/vri_regs_tb_top.sv
// self-checking bench: register port tasks, vme master model, error and auto-id events
// assumes the bound checker; straps first select an enabled a24 window, later a16 off and a32
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module vri_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, csr_cyc = 0, autoid_l2_ack = 0;
  logic berr_evt = 0, berr_iack = 0, reg_busy_ff, win_hit_ff, csr_en_ff, vme_cyc, vme_rmw;
  logic vme_wr, hit, busy;
  logic        pu_win_en = 1;
  logic [11:0] reg_addr = 0;
  logic [23:0] csr_addr = 0;
  logic [5:0]  berr_am = 0, vme_am;
  logic [1:0]  csr_pci_space_ff, pu_space = 2'h1;
  logic [31:0] reg_wdata = 0, berr_addr = 0, rdata, vdata, reg_rdata_ff, vme_rdata_ff;
  logic [31:0] csr_pci_addr_ff, vme_addr, vme_wdata;
  logic [31:0] ctl [3] = '{32'h80610000, 32'h80910000, 32'h80f10000};
  logic [3:0]  msk [3] = '{4'b0100, 4'b0010, 4'b1111};
  logic [5:0]  ams [4] = '{6'h39, 6'h3a, 6'h3d, 6'h3e};
  logic [5:0]  a32 [4] = '{6'h0d, 6'h0e, 6'h0a, 6'h05};
  int failures = 0, n_checks = 0;
  vri_regs dut (.clk_sys, .rst, .pu_win_en, .pu_space, .powerup_address_bits(8'ha5),
    .pu_ofs_mid(5'h15), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_busy_ff,
    .vme_cyc, .vme_addr, .vme_am, .vme_rmw, .vme_wr, .vme_wdata, .win_hit_ff, .vme_rdata_ff,
    .csr_cyc, .csr_addr, .csr_pci_addr_ff, .csr_pci_space_ff, .csr_en_ff, .autoid_l2_ack,
    .berr_evt, .berr_am, .berr_iack, .berr_addr);
  vri_vme_master m (.clk_sys, .win_hit_ff, .vme_rdata_ff, .vme_cyc, .vme_rmw, .vme_wr,
    .vme_addr, .vme_am, .vme_wdata);
  // 100 ns clock
  always #50 clk_sys = ~clk_sys;
  // set the straps and hold reset for six cycles, release off the edge
  task automatic rst_run(input logic en, input logic [1:0] sp);
    {pu_win_en, pu_space, rst} = {en, sp, 1'b1};
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 0;
  endtask
  // register port accesses, answer one cycle later
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1;
    reg_wr = 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1;
    reg_rd = 0;
    d = reg_rdata_ff;
    busy = reg_busy_ff;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    rd(a, rdata);
    `CHK(rdata, e);
  endtask
  // single vme read into the window
  task automatic vc(input logic [31:0] a, input logic [5:0] am, input logic e);
    m.cyc(a, am, 1'b0, 32'h0, 1'b0, 1, hit, vdata);
    `CHK(hit, e);
  endtask
  // csr address translation
  task automatic xl(input logic [23:0] a, input logic [31:0] e, input logic [1:0] s);
    @(posedge clk_sys);
    #1;
    {csr_cyc, csr_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1;
    csr_cyc = 0;
    `CHK(csr_pci_addr_ff, e);
    `CHK(csr_pci_space_ff, s);
  endtask
  // one-cycle bus error or auto-id pulse
  task automatic ev(input logic b, input logic [5:0] am, input logic ia, input logic [31:0] ad);
    @(posedge clk_sys);
    #1;
    {berr_evt, autoid_l2_ack, berr_am, berr_iack, berr_addr} = {b, !b, am, ia, ad};
    @(posedge clk_sys);
    #1;
    {berr_evt, autoid_l2_ack} = 2'h0;
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  // test sequence
  initial begin
    rst_run(1'b1, 2'h1);
    chk_rd(12'hf70, 32'h80f10000);
    chk_rd(12'hf74, 32'h00a50000);
    chk_rd(12'hf80, 32'h0);
    chk_rd(12'hf84, 32'h00a80000);
    chk_rd(12'hf88, 32'h0);
    vc(32'h00a50f70, 6'h39, 1);
    `CHK(vdata, 32'h80f10000);
    vc(32'h00a51000, 6'h39, 0);
    vc(32'h00a4fffc, 6'h39, 0);
    vc(32'h00a50000, 6'h3b, 0);
    vc(32'h00a50000, 6'h32, 1);
    for (int i = 0; i < 3; i++) begin
      wr(12'hf70, ctl[i]);
      for (int j = 0; j < 4; j++)
        vc(32'h00a50004, ams[j], msk[i][j]);
    end
    wr(12'hf70, 32'h00f10000);
    vc(32'h00a50004, 6'h39, 0);
    wr(12'hf74, 32'h12345000);
    wr(12'hf70, 32'h80f20000);
    vc(32'h12345f74, 6'h09, 1);
    `CHK(vdata, 32'h12345000);
    wr(12'hf70, 32'h80f00000);
    vc(32'h00005004, 6'h29, 1);
    fork
      m.cyc(32'h00005f70, 6'h29, 1'b0, 32'h0, 1'b1, 2, hit, vdata);
      begin
        rd(12'hf70, rdata);
        `CHK(busy, 1'b1);
        rd(12'hf70, rdata);
        `CHK(busy, 1'b1);
      end
    join
    @(posedge clk_sys);
    chk_rd(12'hf70, 32'h80f00000);
    m.cyc(32'h00005f84, 6'h29, 1'b1, 32'hff000000, 1'b0, 1, hit, vdata);
    ev(0, 6'h0, 0, 32'h0);
    `CHK(csr_en_ff, 1'b1);
    xl(24'h123456, 32'hff123456, 2'h0);
    wr(12'hf84, 32'h00080000);
    wr(12'hf80, 32'h80000001);
    xl(24'hfffff0, 32'h0107fff0, 2'h1);
    ev(1, 6'h2d, 1, 32'hdeadbee0);
    ev(1, 6'h09, 0, 32'h00000001);
    chk_rd(12'hf88, 32'hb7800000);
    chk_rd(12'hf8c, 32'hdeadbee0);
    wr(12'hf88, 32'h0);
    chk_rd(12'hf88, 32'hb7800000);
    wr(12'hf88, 32'h00800000);
    ev(1, 6'h0d, 0, 32'h00c0ffee);
    chk_rd(12'hf88, 32'h34800000);
    chk_rd(12'hf8c, 32'h00c0ffee);
    // clear and a new error in one cycle: the error wins
    fork
      wr(12'hf88, 32'h00800000);
      ev(1, 6'h3d, 1, 32'h0000beef);
    join
    chk_rd(12'hf88, 32'h35800000);
    chk_rd(12'hf8c, 32'h00c0ffee);
    // mid-run reset with a16 straps and the window off
    rst_run(1'b0, 2'h0);
    `CHK(csr_en_ff, 1'b0);
    chk_rd(12'hf70, 32'h00f00000);
    chk_rd(12'hf74, 32'h0000a000);
    chk_rd(12'hf84, 32'h00a80000);
    chk_rd(12'hf88, 32'h0);
    vc(32'h0000af70, 6'h2d, 0);
    wr(12'hf70, 32'h80f00000);
    vc(32'h0000af70, 6'h2d, 1);
    vc(32'h0000a000, 6'h2c, 1);
    vc(32'h0000b000, 6'h2d, 0);
    // mid-run reset with a32 straps
    rst_run(1'b1, 2'h2);
    chk_rd(12'hf70, 32'h80f20000);
    chk_rd(12'hf74, 32'ha5000000);
    for (int j = 0; j < 4; j++)
      vc(32'ha5000f74, a32[j], 1);
    `CHK(vdata, 32'ha5000000);
    vc(32'ha5000000, 6'h0f, 0);
    wr(12'hf70, 32'h80f30000);
    vc(32'ha5000000, 6'h0d, 0);
    print_verdict();
  end
endmodule // vri_regs_tb_top
